/* File: logic/qhb_defs.svh */
// Purpose: timing counts and reset values for the quad half-bridge control
// Assumes: 100 MHz system clock
// Notes: definitions only
`ifndef QHB_DEFS_SVH
`define QHB_DEFS_SVH

`define QHB_CLK_MHZ 100
`define QHB_OCP_DEGLITCH_NS 5000
`define QHB_OCP_DEGLITCH_CYC ((`QHB_OCP_DEGLITCH_NS * `QHB_CLK_MHZ + 999) / 1000)
`define QHB_WAKE_US 1000
`define QHB_WAKE_CYC (`QHB_WAKE_US * `QHB_CLK_MHZ)
`define QHB_CHANNELS 4
`define QHB_SYNC_RESET_VAL 1'b0

`endif

/* File: logic/qhb_pkg.sv */
// Purpose: types for the quad half-bridge control
// Assumes: nothing
// Notes: timing counts live in qhb_defs.svh
`default_nettype none
package qhb_pkg;
    typedef enum logic [2:0] {
        QHB_ST_HALT = 3'b001,
        QHB_ST_WAKE = 3'b010,
        QHB_ST_RUN = 3'b100
    } qhb_state_e;
endpackage : qhb_pkg
`default_nettype wire

/* File: logic/qhb_sync_if.sv */
// Purpose: carrier of synchronised pin levels between the two design modules
// Assumes: single clock domain
// Notes: none
`timescale 1ns/100ps
`default_nettype none
interface qhb_sync_if #(parameter int N = 4);
    logic [N-1:0] level;
    logic [N-1:0] enable;
    logic [N-1:0] oc_event;
    logic reset_n;
    logic wake_n;
    logic overheat;
    logic supply_low;
    modport src (output level, enable, oc_event, reset_n, wake_n, overheat, supply_low);
    modport dst (input level, enable, oc_event, reset_n, wake_n, overheat, supply_low);
endinterface : qhb_sync_if
`default_nettype wire

/* File: logic/qhb_pin_sync.sv */
// Purpose: two-flop synchronisers for every pin-level input
// Assumes: undriven pins already resolve to 0 at the pad
// Notes: first stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none
`include "qhb_defs.svh"
module qhb_pin_sync #(
    parameter int N = 4
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic [N-1:0] level_i,
    input wire logic [N-1:0] enable_i,
    input wire logic [N-1:0] oc_event_i,
    input wire logic reset_n_i,
    input wire logic wake_n_i,
    input wire logic overheat_i,
    input wire logic supply_low_i,
    qhb_sync_if.src sync
);
    localparam int W = 3 * N + 4;
    logic [W-1:0] stage1_reg;
    logic [W-1:0] stage2_reg;

    // ----------------------------------------
    // two-flop synchroniser
    // ----------------------------------------
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end else begin
            stage1_reg <= {level_i, enable_i, oc_event_i, reset_n_i, wake_n_i, overheat_i, supply_low_i};
            stage2_reg <= stage1_reg;
        end
    end

    assign sync.level = stage2_reg[W-1 -: N];
    assign sync.enable = stage2_reg[2*N+3 -: N];
    assign sync.oc_event = stage2_reg[N+3 -: N];
    assign sync.reset_n = stage2_reg[3];
    assign sync.wake_n = stage2_reg[2];
    assign sync.overheat = stage2_reg[1];
    assign sync.supply_low = stage2_reg[0];
endmodule : qhb_pin_sync
`default_nettype wire

/* File: logic/qhb_ctrl.sv */
// Purpose: control logic for four half-bridge outputs with protection
// Assumes: pins are sampled on a 100 MHz clock; pulldowns at the pads
// Notes: output enable high means the half-bridge drives its pin
`timescale 1ns/100ps
`default_nettype none
`include "qhb_defs.svh"
// How it works
// - four identical channels, each steered by its own level and enable
// - enable low floats the channel output regardless of level
// - enable high drives output equal to the level input
// - logic reset low clears overcurrent latches and deglitch counters and disables all outputs; sleep/wake state is kept
// - sleep request low enters low-power state; high runs normally
// - fault flag pulled low on overheat, overcurrent or supply low
// - undriven control inputs read as zero
// - overcurrent counts only after persisting the 5 us deglitch time
// - qualified overcurrent latches off that channel until reset
// - supply low disables outputs, resets logic, recovers automatically
// - inputs ignored in sleep; about 1 ms before full operation after wake
// - overheat disables all outputs, recovers automatically
module qhb_ctrl #(
    parameter int N = `QHB_CHANNELS,
    parameter int OCP_CYC = `QHB_OCP_DEGLITCH_CYC,
    parameter int WAKE_CYC = `QHB_WAKE_CYC
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic [N-1:0] channel_level_in_i,
    input wire logic [N-1:0] channel_drive_enable_i,
    input wire logic [N-1:0] overcurrent_guard_i,
    input wire logic logic_reset_n_i,
    input wire logic low_power_request_n_i,
    input wire logic overheat_shutdown_i,
    input wire logic supply_low_lockout_i,
    output logic [N-1:0] half_bridge_out_o,
    output logic [N-1:0] half_bridge_oe_o,
    output logic fault_flag_n_o,
    output logic fault_flag_n_oe_o,
    output logic sleeping_o,
    output logic [N-1:0] oc_latched_o,
    output var qhb_pkg::qhb_state_e state_o
);
    import qhb_pkg::*;

    localparam int CW = $clog2(WAKE_CYC + 1);
    localparam int OW = $clog2(OCP_CYC + 1);

    qhb_sync_if #(.N(N)) sync ();
    qhb_state_e state_reg;
    qhb_state_e state_next;
    logic [CW-1:0] wake_cnt_reg;
    logic [N-1:0] oc_latch_reg;
    logic [N-1:0] out_reg;
    logic [N-1:0] oe_reg;
    logic fault_reg;
    logic logic_clear;

    // pulldowns at the pads give 0 for undriven pins
    qhb_pin_sync #(.N(N)) u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .level_i(channel_level_in_i),
        .enable_i(channel_drive_enable_i),
        .oc_event_i(overcurrent_guard_i),
        .reset_n_i(logic_reset_n_i),
        .wake_n_i(low_power_request_n_i),
        .overheat_i(overheat_shutdown_i),
        .supply_low_i(supply_low_lockout_i),
        .sync(sync)
    );

    assign logic_clear = !sync.reset_n || sync.supply_low;

    // ----------------------------------------
    // sleep and wake sequencing
    // ----------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            QHB_ST_HALT: if (sync.wake_n) state_next = QHB_ST_WAKE;
            QHB_ST_WAKE: begin
                if (!sync.wake_n) state_next = QHB_ST_HALT;
                else if (wake_cnt_reg == CW'(WAKE_CYC - 1)) state_next = QHB_ST_RUN;
            end
            QHB_ST_RUN: if (!sync.wake_n) state_next = QHB_ST_HALT;
            default: state_next = QHB_ST_HALT;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_reg <= QHB_ST_HALT;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wake_cnt_reg <= '0;
        end else if (state_reg == QHB_ST_WAKE) begin
            wake_cnt_reg <= wake_cnt_reg + CW'(1);
        end else begin
            wake_cnt_reg <= '0;
        end
    end

    // ----------------------------------------
    // per-channel deglitch, latch and drive
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_ch
            logic [OW-1:0] ocp_cnt_reg;
            always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    ocp_cnt_reg <= '0;
                end else if (!sync.oc_event[g] || logic_clear || state_reg != QHB_ST_RUN) begin
                    ocp_cnt_reg <= '0;
                end else if (ocp_cnt_reg != OW'(OCP_CYC)) begin
                    ocp_cnt_reg <= ocp_cnt_reg + OW'(1);
                end
            end

            always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    oc_latch_reg[g] <= 1'b0;
                end else if (logic_clear) begin
                    oc_latch_reg[g] <= 1'b0;
                end else if (ocp_cnt_reg == OW'(OCP_CYC - 1) && sync.oc_event[g]) begin
                    oc_latch_reg[g] <= 1'b1;
                end
            end

            always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    out_reg[g] <= 1'b0;
                    oe_reg[g] <= 1'b0;
                end else if (logic_clear || sync.overheat || state_reg != QHB_ST_RUN || oc_latch_reg[g]) begin
                    out_reg[g] <= 1'b0;
                    oe_reg[g] <= 1'b0;
                end else begin
                    out_reg[g] <= sync.level[g];
                    oe_reg[g] <= sync.enable[g];
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // fault flag
    // ----------------------------------------
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fault_reg <= 1'b0;
        end else begin
            fault_reg <= sync.overheat || sync.supply_low || (|oc_latch_reg);
        end
    end

    assign half_bridge_out_o = out_reg;
    assign half_bridge_oe_o = oe_reg;
    assign fault_flag_n_o = 1'b0;
    assign fault_flag_n_oe_o = fault_reg;
    assign sleeping_o = (state_reg == QHB_ST_HALT);
    assign oc_latched_o = oc_latch_reg;
    assign state_o = state_reg;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_disabled_floats;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        !sync.enable[0] |=> !half_bridge_oe_o[0];
    endproperty
    a_disabled_floats: assert property (p_disabled_floats) else $error("disabled channel driven");

    property p_follows_level;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (sync.enable[1] && state_reg == QHB_ST_RUN && !logic_clear && !sync.overheat && !oc_latch_reg[1])
        |=> half_bridge_oe_o[1] && half_bridge_out_o[1] == $past(sync.level[1]);
    endproperty
    a_follows_level: assert property (p_follows_level) else $error("output not following level");

    property p_reset_off;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        !sync.reset_n |=> half_bridge_oe_o == '0 && oc_latched_o == '0;
    endproperty
    a_reset_off: assert property (p_reset_off) else $error("outputs on during logic reset");

    property p_sleep_off;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        !sync.wake_n |=> sleeping_o ##1 half_bridge_oe_o == '0;
    endproperty
    a_sleep_off: assert property (p_sleep_off) else $error("sleep not entered");

    property p_fault_flag;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (sync.overheat || sync.supply_low || |oc_latch_reg) |=> fault_flag_n_oe_o;
    endproperty
    a_fault_flag: assert property (p_fault_flag) else $error("fault flag not pulled");

    logic ocp_cnt0_full;
    assign ocp_cnt0_full = (g_ch[0].ocp_cnt_reg == OW'(OCP_CYC - 1));

    property p_deglitch;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        $rose(oc_latch_reg[0]) |-> $past(ocp_cnt0_full);
    endproperty
    a_deglitch: assert property (p_deglitch) else $error("overcurrent latched early");

    property p_oc_hold;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (oc_latch_reg[0] && !logic_clear) |=> oc_latch_reg[0] && !half_bridge_oe_o[0];
    endproperty
    a_oc_hold: assert property (p_oc_hold) else $error("overcurrent channel released");

    property p_overheat_off;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        sync.overheat |=> half_bridge_oe_o == '0;
    endproperty
    a_overheat_off: assert property (p_overheat_off) else $error("outputs on in overheat");

    property p_wake_time;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        $rose(state_reg == QHB_ST_WAKE) |-> state_reg != QHB_ST_RUN [*8];
    endproperty
    a_wake_time: assert property (p_wake_time) else $error("run reached too early after wake");
endmodule : qhb_ctrl
`default_nettype wire

/* File: sim/qhb_mcu_model.sv */
// Purpose: controller model driving the level and enable pins
// Assumes: pins change at the falling clock edge
// Notes: mode 0 passes static levels, 1 fast decay, 2 slow forward, 3 slow reverse
`timescale 1ns/100ps
`default_nettype none
module qhb_mcu_model (
    input wire logic sys_clk_i,
    input wire logic [1:0] mode_i,
    input wire logic [3:0] lvl_i,
    input wire logic [3:0] en_i,
    output logic [3:0] lvl_o,
    output logic [3:0] en_o
);
    logic [2:0] cnt = 3'h0;
    logic pwm;
    always @(negedge sys_clk_i) begin
        cnt <= cnt + 3'h1;
    end
    assign pwm = cnt[2];
    always_comb begin
        lvl_o = lvl_i;
        en_o = en_i;
        case (mode_i)
            2'h1: begin
                lvl_o[1:0] = 2'b01;
                en_o[1:0] = {pwm, pwm};
            end
            2'h2: begin
                lvl_o[1:0] = {1'b0, pwm};
                en_o[1:0] = 2'b11;
            end
            2'h3: begin
                lvl_o[1:0] = {pwm, 1'b0};
                en_o[1:0] = 2'b11;
            end
            default: begin
            end
        endcase
    end
endmodule : qhb_mcu_model
`default_nettype wire

/* File: sim/tb_top.sv */
// Purpose: self-checking bench for the quad half-bridge control
// Assumes: short wake and deglitch counts
// Notes: inputs change at the falling edge
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import qhb_pkg::*;
    // ----------------------------------------
    // signals and instances
    // ----------------------------------------
    logic sys_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [1:0] mode = 2'h0;
    logic [3:0] lvl = 4'h0, en = 4'h0, lvl_p, en_p, oc = 4'h0;
    logic rst_n = 1'b0, wake_n = 1'b0, heat = 1'b0, slow = 1'b0;
    logic [3:0] out, oe, ocl;
    logic fl_n, fl_oe, slp;
    qhb_state_e st;
    int bad_count = 0, checked = 0, cycles = 0;
    always #5 sys_clk_i = ~sys_clk_i;
    qhb_mcu_model i_qhb_mcu_model (.sys_clk_i(sys_clk_i), .mode_i(mode), .lvl_i(lvl), .en_i(en),
        .lvl_o(lvl_p), .en_o(en_p));
    qhb_ctrl #(.OCP_CYC(10), .WAKE_CYC(20)) i_qhb_ctrl (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
        .channel_level_in_i(lvl_p), .channel_drive_enable_i(en_p), .overcurrent_guard_i(oc),
        .logic_reset_n_i(rst_n), .low_power_request_n_i(wake_n), .overheat_shutdown_i(heat),
        .supply_low_lockout_i(slow), .half_bridge_out_o(out), .half_bridge_oe_o(oe),
        .fault_flag_n_o(fl_n), .fault_flag_n_oe_o(fl_oe), .sleeping_o(slp), .oc_latched_o(ocl),
        .state_o(st));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic test_done();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk
    task automatic w(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask : w
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            test_done();
        end
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_wake();
        chk("state", {5'h00, st}, {5'h00, QHB_ST_HALT});
        chk("sleep", {7'h00, slp}, 8'h01);
        en = 4'hF;
        lvl = 4'hA;
        rst_n = 1'b1;
        wake_n = 1'b1;
        w(10);
        chk("wake_oe", {4'h0, oe}, 8'h00);
        w(30);
        chk("run_state", {5'h00, st}, {5'h00, QHB_ST_RUN});
        chk("run_oe", {4'h0, oe}, 8'h0F);
        chk("run_out", {4'h0, out}, 8'h0A);
    endtask : t_wake
    task automatic t_table();
        for (int i = 0; i < 16; i++) begin
            en = 4'(i);
            lvl = ~4'(i * 3);
            w(4);
            chk("tab_oe", {4'h0, oe}, {4'h0, en});
            chk("tab_out", {4'h0, out & en}, {4'h0, lvl & en});
        end
    endtask : t_table
    task automatic t_pwm(input logic [1:0] md, input logic [3:0] e_any, input logic [3:0] e_all,
        input logic [3:0] msk);
        logic [3:0] a, b;
        a = 4'h0;
        b = 4'hF;
        en = 4'h0;
        mode = md;
        w(4);
        repeat (24) begin
            w(1);
            a = a | {oe[1:0], out[1:0]};
            b = b & {oe[1:0], out[1:0]};
        end
        chk("pwm_any", {4'h0, a & msk}, {4'h0, e_any});
        chk("pwm_all", {4'h0, b & msk}, {4'h0, e_all});
        mode = 2'h0;
    endtask : t_pwm
    task automatic t_ocp();
        en = 4'h3;
        lvl = 4'h3;
        oc = 4'h1;
        w(6);
        oc = 4'h0;
        w(6);
        chk("ocp_short", {3'h0, fl_oe, ocl}, 8'h00);
        oc = 4'h1;
        w(20);
        oc = 4'h0;
        w(4);
        chk("ocp_latch", {3'h0, fl_oe, ocl}, 8'h11);
        chk("ocp_oe", {3'h0, fl_n, oe}, 8'h02);
        rst_n = 1'b0;
        w(4);
        chk("rst_oe", {4'h0, oe}, 8'h00);
        rst_n = 1'b1;
        w(4);
        chk("rst_clr", {3'h0, fl_oe, ocl}, 8'h00);
        chk("rst_oe2", {4'h0, oe}, 8'h03);
    endtask : t_ocp
    task automatic t_fault(input logic sel);
        heat = ~sel;
        slow = sel;
        w(4);
        chk("flt_on", {3'h0, fl_oe, oe}, 8'h10);
        heat = 1'b0;
        slow = 1'b0;
        w(4);
        chk("flt_off", {3'h0, fl_oe, oe}, 8'h03);
    endtask : t_fault
    task automatic t_sleep();
        wake_n = 1'b0;
        w(4);
        chk("slp", {3'h0, slp, oe}, 8'h10);
        en = 4'hF;
        w(4);
        chk("slp_ign", {4'h0, oe}, 8'h00);
        wake_n = 1'b1;
        w(30);
        chk("slp_back", {4'h0, oe}, 8'h0F);
    endtask : t_sleep
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        w(2);
        rst_b_i = 1'b1;
        w(1);
        t_wake();
        t_table();
        t_pwm(2'h1, 4'hC, 4'h0, 4'hC);
        t_pwm(2'h2, 4'hD, 4'hC, 4'hF);
        t_pwm(2'h3, 4'hE, 4'hC, 4'hF);
        t_ocp();
        t_fault(1'b0);
        t_fault(1'b1);
        t_sleep();
        test_done();
    end
endmodule : tb_top
`default_nettype wire
